/* verilog/bsp_port.sv */
// Basic byte-wide serial port with its registers and clock sources.

module bsp_port (
    input wire logic clock,
    input wire logic sys_rst,
    input wire bsp_pkg::bsp_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic ext_write_strobe,
    input wire logic timer0_overflow_out,
    input wire logic timer1_overflow_out,
    input wire bsp_pkg::bsp_gpio_t gpio,
    input wire logic link_sck,
    input wire logic ss_n_i,
    input wire logic din_i,
    output logic sck_o,
    output logic sck_oe,
    output logic dout_o,
    output logic dout_oe,
    output logic byte_count_interrupt
);

    // Software visible registers.
    logic [7:0] serial_control_reg_q; // Mode bits in the low five.
    logic [7:0] sck_source_select_q; // Source code and soft level.
    logic [7:0] aux_interrupt_enable_q; // Enable bits.
    logic [7:0] power_control_reg_q; // Power-down bits.
    logic [7:0] tx_q; // Byte to send.
    logic [7:0] rx_q; // Byte last received.
    logic [7:0] rdata_q; // Registered read answer.

    // Status and link control flops.
    logic flag_q; // Byte complete, sticky.
    logic flag_d;
    logic sck_q; // Master serial clock level.
    logic sck_d;
    logic link_rst_q; // Clears the link's received byte and byte toggle.
    logic cnt_rst_q; // Restarts the link counter.

    // Synchronisers from the link and the select pin.
    logic [2:0] gray_s1_q; // First stage, read by stage two only.
    logic [2:0] gray_s2_q;
    logic done_s1_q; // First stage, read by stage two only.
    logic done_s2_q;
    logic done_s3_q; // Previous value for the edge.
    logic ss_s1_q; // First stage, read by stage two only.
    logic ss_s2_q;

    // Wires from the link side.
    logic link_dout;
    logic [2:0] link_cnt_gray;
    logic link_done_tgl;
    logic [7:0] link_rx;

    // Decoded configuration fields.
    wire bsp_pkg::bsp_cfg_t cfg;
    assign cfg.cpha = serial_control_reg_q[bsp_pkg::CTRL_CPHA];
    assign cfg.cpol = serial_control_reg_q[bsp_pkg::CTRL_CPOL];
    assign cfg.lsb_first = serial_control_reg_q[bsp_pkg::CTRL_LSB];
    assign cfg.master = serial_control_reg_q[bsp_pkg::CTRL_MASTER];
    assign cfg.slave_select_enable = serial_control_reg_q[bsp_pkg::CTRL_ESS];

    // The port only works while its power-down bit is clear.
    wire logic powered_down;
    assign powered_down = power_control_reg_q[bsp_pkg::PD_SPI_BIT];

    // Selected clock source; unused codes fall to the default arm.
    wire bsp_pkg::bsp_src_t src_sel;
    assign src_sel = bsp_pkg::bsp_src_t'(sck_source_select_q[2:0]);

    // Address decode of the register bus.
    wire logic hit_ctrl;
    wire logic hit_data;
    wire logic hit_aie;
    wire logic hit_pd;
    wire logic hit_src;
    assign hit_ctrl = sfr_req.addr == bsp_pkg::ADDR_CTRL;
    assign hit_data = sfr_req.addr == bsp_pkg::ADDR_DATA;
    assign hit_aie = sfr_req.addr == bsp_pkg::ADDR_AIE;
    assign hit_pd = sfr_req.addr == bsp_pkg::ADDR_POWER_CONTROL_REG;
    assign hit_src = sfr_req.addr == bsp_pkg::ADDR_SRCSEL;

    // Any read or write of the data register counts as an access.
    wire logic data_access;
    assign data_access = hit_data & (sfr_req.wr | sfr_req.rd);

    // Live bit count recovered from the crossed gray code.
    wire logic [2:0] live_cnt;
    assign live_cnt = bsp_pkg::gray_to_bin(gray_s2_q);

    // Two system cycles after the link flips its byte toggle.
    wire logic byte_done;
    assign byte_done = done_s2_q ^ done_s3_q;

    // A new transfer has begun once the count leaves zero.
    wire logic new_transfer;
    assign new_transfer = live_cnt != bsp_pkg::CNT_ZERO;

    // Read multiplexer; undefined addresses answer zero.
    wire logic [7:0] read_mux;
    assign read_mux =
        hit_ctrl ? {live_cnt, serial_control_reg_q[4:0]} :
        hit_data ? rx_q :
        hit_aie ? aux_interrupt_enable_q :
        hit_pd ? power_control_reg_q :
        hit_src ? sck_source_select_q : 8'h00;

    // Interrupt flag: set wins over clear and over withdrawal.
    always_comb begin
        flag_d = flag_q;
        if (data_access) begin
            flag_d = 1'b0;
        end else if (new_transfer) begin
            flag_d = 1'b0;
        end
        if (byte_done) begin
            flag_d = 1'b1;
        end
    end

    // Next master clock level from the chosen source.
    always_comb begin
        unique case (src_sel)
            bsp_pkg::SRC_SOFT: begin
                sck_d = sck_source_select_q[bsp_pkg::SRC_SOFT_BIT];
            end
            bsp_pkg::SRC_WR_PULSE: begin
                // Idle high, low for the strobe; needs polarity one.
                sck_d = ~ext_write_strobe;
            end
            bsp_pkg::SRC_WR_TOGGLE: begin
                sck_d = sck_q ^ ext_write_strobe;
            end
            bsp_pkg::SRC_T0_PULSE: begin
                // Idle low; only usable with polarity zero.
                sck_d = timer0_overflow_out;
            end
            bsp_pkg::SRC_T0_TOGGLE: begin
                sck_d = sck_q ^ timer0_overflow_out;
            end
            bsp_pkg::SRC_T1_PULSE: begin
                sck_d = timer1_overflow_out;
            end
            bsp_pkg::SRC_T1_TOGGLE: begin
                sck_d = sck_q ^ timer1_overflow_out;
            end
            default: begin
                // Unused code parks the clock at its idle level.
                sck_d = cfg.cpol;
            end
        endcase
    end

    // Control register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            serial_control_reg_q <= bsp_pkg::RST_CTRL;
        end else if (sfr_req.wr && hit_ctrl) begin
            serial_control_reg_q <= {3'h0, sfr_req.wdata[4:0]};
        end
    end

    // Clock source select register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sck_source_select_q <= bsp_pkg::RST_SRCSEL;
        end else if (sfr_req.wr && hit_src) begin
            sck_source_select_q <= sfr_req.wdata;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            aux_interrupt_enable_q <= bsp_pkg::RST_AIE;
        end else if (sfr_req.wr && hit_aie) begin
            aux_interrupt_enable_q <= sfr_req.wdata;
        end
    end

    // Power control register.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            power_control_reg_q <= bsp_pkg::RST_POWER_CONTROL_REG;
        end else if (sfr_req.wr && hit_pd) begin
            power_control_reg_q <= sfr_req.wdata;
        end
    end

    // Transmit byte; software must not change it mid byte.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            tx_q <= bsp_pkg::RST_DATA;
        end else if (sfr_req.wr && hit_data) begin
            tx_q <= sfr_req.wdata;
        end
    end

    // Received byte; an unread one is simply replaced.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rx_q <= bsp_pkg::RST_DATA;
        end else if (byte_done) begin
            rx_q <= link_rx;
        end
    end

    // Read answer, one cycle after the read strobe.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (sfr_req.rd) begin
            rdata_q <= read_mux;
        end
    end

    // Sticky byte-complete flag.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    // Master clock; held at idle polarity outside master mode.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sck_q <= 1'b0;
        end else if (!cfg.master || powered_down) begin
            sck_q <= cfg.cpol;
        end else begin
            sck_q <= sck_d;
        end
    end

    // Link resets are flops so they never glitch from decode.
    // The link clock may stand still, so its reset acts at once.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            link_rst_q <= 1'b1;
            cnt_rst_q <= 1'b1;
        end else begin
            link_rst_q <= powered_down;
            cnt_rst_q <= powered_down | data_access;
        end
    end

    // Link count and byte toggle cross on two flops each.
    // Gray code keeps the count coherent while it moves.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            gray_s1_q <= 3'h0;
            gray_s2_q <= 3'h0;
            done_s1_q <= 1'b0;
            done_s2_q <= 1'b0;
            done_s3_q <= 1'b0;
        end else begin
            gray_s1_q <= link_cnt_gray;
            gray_s2_q <= gray_s1_q;
            done_s1_q <= link_done_tgl;
            done_s2_q <= done_s1_q;
            done_s3_q <= done_s2_q;
        end
    end

    // Select pin as seen by the output enable.
    // The two cycle lag asks the master for select setup.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ss_s1_q <= 1'b1;
            ss_s2_q <= 1'b1;
        end else begin
            ss_s1_q <= ss_n_i;
            ss_s2_q <= ss_s1_q;
        end
    end

    // Shifter on the serial clock. The select line is a frame
    // signal of that clock, so the link samples it directly.
    bsp_link u_link (
        .link_sck(link_sck),
        .link_rst(link_rst_q),
        .cnt_rst(cnt_rst_q),
        .cfg(cfg),
        .ss_n(ss_n_i),
        .din(din_i),
        .tx_data(tx_q),
        .dout(link_dout),
        .cnt_gray(link_cnt_gray),
        .done_tgl(link_done_tgl),
        .rx_byte(link_rx)
    );

    // Clock pin: latch drive when down, else only a master drives it.
    assign sck_o = powered_down ? gpio.sck_o : sck_q;
    assign sck_oe = powered_down ? gpio.sck_oe : cfg.master;

    // Output pin: latch drive when down, else the shifter.
    assign dout_o = powered_down ? gpio.dout_o : link_dout;
    assign dout_oe = powered_down ? gpio.dout_oe :
                     (cfg.master | ~cfg.slave_select_enable | ~ss_s2_q);

    assign sfr_rdata = rdata_q;
    assign byte_count_interrupt =
        flag_q & aux_interrupt_enable_q[bsp_pkg::AIE_CNT_BIT];

endmodule

/* verilog/bsp_pkg.sv */
// Shared constants, types and helpers for the basic serial port.
package bsp_pkg;

    // Special function register addresses of the port.
    localparam logic [7:0] ADDR_CTRL = 8'h9A;
    localparam logic [7:0] ADDR_DATA = 8'h9B;
    localparam logic [7:0] ADDR_AIE = 8'hA6;
    localparam logic [7:0] ADDR_POWER_CONTROL_REG = 8'hF1;
    localparam logic [7:0] ADDR_SRCSEL = 8'hF2;

    // Field positions inside the control register.
    localparam int CTRL_CPHA = 0;
    localparam int CTRL_CPOL = 1;
    localparam int CTRL_LSB = 2;
    localparam int CTRL_MASTER = 3;
    localparam int CTRL_ESS = 4;
    localparam int CTRL_CNT_LO = 5;

    // Field positions in the other registers.
    localparam int SRC_SOFT_BIT = 7;
    localparam int AIE_CNT_BIT = 2;
    localparam int PD_SPI_BIT = 0;

    // Values after reset; the port starts powered down.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_SRCSEL = 8'h00;
    localparam logic [7:0] RST_AIE = 8'h00;
    localparam logic [7:0] RST_POWER_CONTROL_REG = 8'h01;
    localparam logic [7:0] RST_DATA = 8'h00;

    // Bits in one byte transfer and the counter value that ends it.
    localparam int BYTE_BITS = 8;
    localparam logic [2:0] CNT_LAST = 3'h7;
    localparam logic [2:0] CNT_ZERO = 3'h0;

    // Sources of the master serial clock.
    typedef enum logic [2:0] {
        SRC_SOFT = 3'b000,
        SRC_WR_PULSE = 3'b001,
        SRC_WR_TOGGLE = 3'b010,
        SRC_T0_PULSE = 3'b011,
        SRC_T0_TOGGLE = 3'b100,
        SRC_T1_PULSE = 3'b101,
        SRC_T1_TOGGLE = 3'b110
    } bsp_src_t;

    // One register bus request.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bsp_sfr_req_t;

    // Transfer configuration handed to the link side.
    typedef struct packed {
        logic cpha;
        logic cpol;
        logic lsb_first;
        logic master;
        logic slave_select_enable;
    } bsp_cfg_t;

    // Port latch drive used while the port is powered down.
    typedef struct packed {
        logic sck_o;
        logic sck_oe;
        logic dout_o;
        logic dout_oe;
    } bsp_gpio_t;

    // Converts a counter value to gray code for crossing.
    function automatic logic [2:0] bin_to_gray(input logic [2:0] b);
        return b ^ (b >> 1);
    endfunction

    // Recovers the counter value from its gray code.
    function automatic logic [2:0] gray_to_bin(input logic [2:0] g);
        return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
    endfunction

endpackage

/* verilog/bsp_link.sv */
// Link side shifter of the serial port, clocked by the serial clock pin.
module bsp_link (
    input wire logic link_sck,
    input wire logic link_rst,
    input wire logic cnt_rst,
    input wire bsp_pkg::bsp_cfg_t cfg,
    input wire logic ss_n,
    input wire logic din,
    input wire logic [7:0] tx_data,
    output logic dout,
    output logic [2:0] cnt_gray,
    output logic done_tgl,
    output logic [7:0] rx_byte
);

    // Picks the bit that goes out next from a byte.
    function automatic logic pick_out(input logic [7:0] b,
                                      input logic lsb);
        return lsb ? b[0] : b[7];
    endfunction

    // Capture edges become rising edges of this clock for all modes.
    wire logic shift_clk;
    assign shift_clk = link_sck ^ (cfg.cpol ^ cfg.cpha);

    logic [7:0] sh_q; // Bits still to send, received bits behind.
    logic [2:0] cnt_q; // Bits captured in this byte.
    logic out_q; // Bit launched on the launch edge.
    logic [7:0] rx_q; // Last complete received byte.
    logic done_q; // Flips once per complete byte.

    // A deselected slave neither shifts nor counts.
    wire logic gate_open;
    assign gate_open = cfg.master | ~cfg.slave_select_enable | ~ss_n;

    // The first bit of a byte comes straight from the data register.
    wire logic [7:0] src;
    assign src = (cnt_q == bsp_pkg::CNT_ZERO) ? tx_data : sh_q;

    // Received bit enters at the end opposite the one the sent bit leaves from.
    wire logic [7:0] shifted;
    assign shifted = cfg.lsb_first ? {din, src[7:1]}
                                   : {src[6:0], din};

    // Capture edge: shift in and count, wrapping after eight.
    always_ff @(posedge shift_clk or posedge cnt_rst) begin
        if (cnt_rst) begin
            sh_q <= 8'h00;
            cnt_q <= bsp_pkg::CNT_ZERO;
        end else if (gate_open) begin
            sh_q <= shifted;
            cnt_q <= cnt_q + 3'h1;
        end
    end

    // Capture edge of the eighth bit publishes the byte.
    always_ff @(posedge shift_clk or posedge link_rst) begin
        if (link_rst) begin
            rx_q <= 8'h00;
            done_q <= 1'b0;
        end else if (gate_open && cnt_q == bsp_pkg::CNT_LAST) begin
            rx_q <= shifted;
            done_q <= ~done_q;
        end
    end

    // Launch edge: present the next bit until the next capture.
    always_ff @(negedge shift_clk or posedge cnt_rst) begin
        if (cnt_rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= pick_out(src, cfg.lsb_first);
        end
    end

    // With phase zero the first bit must stand before any edge.
    assign dout = (~cfg.cpha && cnt_q == bsp_pkg::CNT_ZERO)
                  ? pick_out(tx_data, cfg.lsb_first) : out_q;
    assign cnt_gray = bsp_pkg::bin_to_gray(cnt_q);
    assign done_tgl = done_q;
    assign rx_byte = rx_q;

endmodule

/* verification/bsp_port_checker.sv */
// Concurrent checks on the serial port pins and register bus.
module bsp_port_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire bsp_pkg::bsp_sfr_req_t sfr_req,
    input wire logic ext_write_strobe,
    input wire logic timer0_overflow_out,
    input wire logic timer1_overflow_out,
    input wire bsp_pkg::bsp_gpio_t gpio,
    input wire logic ss_n_i,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic dout_o,
    input wire logic dout_oe,
    input wire logic byte_count_interrupt
);
    // Mirror of the mode bits, kept from the register writes seen.
    logic pd_q, ms_q, es_q, en_q;
    logic [7:0] src_q;
    logic [1:0] wr_q;
    wire w = sfr_req.wr;
    wire [7:0] a = sfr_req.addr;
    wire [7:0] d = sfr_req.wdata;
    // Checks other than a_irq_data_clear wait two cycles after any write so the mode has settled.
    wire st = !w && wr_q == 2'h0;
    wire [2:0] sm = src_q[2:0];
    wire mact = st && !pd_q && ms_q;
    wire slv = st && !pd_q && !ms_q && es_q;
    wire ispul = sm == 3'h1 || sm == 3'h3 || sm == 3'h5;
    wire istog = sm == 3'h2 || sm == 3'h4 || sm == 3'h6;
    wire wrp = sm == bsp_pkg::SRC_WR_PULSE;
    wire [3:0] stb = {1'b0, timer1_overflow_out, timer0_overflow_out,
        ext_write_strobe};
    wire sel = stb[(sm - 3'h1) >> 1];
    // The port starts powered down, as the register reset says.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pd_q <= 1'b1;
            ms_q <= 1'b0;
            es_q <= 1'b0;
            en_q <= 1'b0;
            src_q <= 8'h00;
        end else if (w) begin
            if (a == bsp_pkg::ADDR_POWER_CONTROL_REG) pd_q <= d[0];
            if (a == bsp_pkg::ADDR_CTRL) ms_q <= d[3];
            if (a == bsp_pkg::ADDR_CTRL) es_q <= d[4];
            if (a == bsp_pkg::ADDR_AIE) en_q <= d[2];
            if (a == bsp_pkg::ADDR_SRCSEL) src_q <= d;
        end
    end
    // Write history; reset counts as unsettled.
    always_ff @(posedge clock) begin
        wr_q <= sys_rst ? 2'h3 : {wr_q[0], w};
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Select held at one level for three cycles outlasts its synchroniser.
    sequence s_slv(b);
        (slv && ss_n_i == b) [*3];
    endsequence
    a_pd_gpio_pins: assert property (
        st && pd_q && $stable(gpio) |->
        {sck_o, sck_oe, dout_o, dout_oe} == gpio)
        else $error("pins differ from port latches");
    a_slave_no_sck: assert property (
        st && !pd_q && !ms_q |-> !sck_oe)
        else $error("slave drives serial clock");
    a_master_drives_sck: assert property (
        mact |-> sck_oe)
        else $error("master leaves serial clock undriven");
    a_soft_clock_level: assert property (
        mact && sm == 3'h0 |-> sck_o == src_q[7])
        else $error("software clock level wrong");
    a_pulse_source_form: assert property (
        mact && ispul |=> sck_o == ($past(sel) != $past(wrp)))
        else $error("pulse source clock wrong");
    a_toggle_quiet_hold: assert property (
        (mact && istog && !sel) [*3] |-> $stable(sck_o))
        else $error("toggle clock moved without event");
    a_toggle_event_flip: assert property (
        mact && istog && sel |-> ##[1:2] $changed(sck_o))
        else $error("toggle clock missed an event");
    a_dout_driven_sel: assert property (
        s_slv(1'b0) |-> dout_oe)
        else $error("selected slave not driving data");
    a_dout_float_desel: assert property (
        s_slv(1'b1) |-> !dout_oe)
        else $error("deselected slave drives data");
    a_irq_masked_off: assert property (
        st && !en_q |-> !byte_count_interrupt)
        else $error("interrupt while disabled");
    a_irq_data_clear: assert property (
        (sfr_req.rd || w) && a == bsp_pkg::ADDR_DATA |=>
        !byte_count_interrupt)
        else $error("data access left interrupt set");
endmodule
bind bsp_port bsp_port_checker bsp_port_checker_i (
    .clock(clock), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .ext_write_strobe(ext_write_strobe), .gpio(gpio), .ss_n_i(ss_n_i),
    .timer0_overflow_out(timer0_overflow_out), .sck_o(sck_o),
    .timer1_overflow_out(timer1_overflow_out), .sck_oe(sck_oe),
    .dout_o(dout_o), .dout_oe(dout_oe),
    .byte_count_interrupt(byte_count_interrupt)
);

/* verification/bsp_ext_master.sv */
// Behavioural external master that clocks the port in slave mode.
module bsp_ext_master (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    // Clock stands still between frames; select idles high.
    initial begin
        sck = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // One frame of nb bits at a 30 ns clock, most significant first.
    task automatic xfer(input logic [7:0] tx, input logic cpol,
        input logic cpha, input int nb, input logic keep_hi,
        output logic [7:0] rx);
        rx = 8'h00;
        sck = cpol;
        ss_n = keep_hi;
        #90;
        for (int i = 7; i > 7 - nb; i--) begin
            if (!cpha) mosi = tx[i];
            #15 sck = !cpol;
            if (cpha) mosi = tx[i];
            else rx[i] = miso;
            #15 sck = cpol;
            if (cpha) rx[i] = miso;
        end
        #45 ss_n = 1'b1;
        // Released data line must not look like a held bit.
        mosi = !mosi;
    endtask
endmodule

/* verification/bsp_port_test.sv */
// Self-checking testbench of the basic serial port.
module bsp_port_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    bsp_pkg::bsp_sfr_req_t sfr_req = '0;
    bsp_pkg::bsp_gpio_t gpio = '0;
    logic [2:0] stb = 3'h0;
    logic [7:0] sfr_rdata, rdv, mrx;
    logic sck_o, sck_oe, dout_o, dout_oe, irq, m_sck, m_ss_n, m_mosi;
    int n_fail = 0;
    int samples_checked = 0;
    // A master port hears itself: clock and data are looped back.
    wire link_sck = sck_oe ? sck_o : m_sck;
    wire din = sck_oe ? dout_o : m_mosi;
    wire miso = dout_oe ? dout_o : 1'bz;
    bsp_port bsp_port_i (
        .clock(clock), .sys_rst(sys_rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .ext_write_strobe(stb[0]),
        .timer0_overflow_out(stb[1]), .timer1_overflow_out(stb[2]),
        .gpio(gpio), .link_sck(link_sck), .ss_n_i(m_ss_n),
        .din_i(din), .sck_o(sck_o), .sck_oe(sck_oe), .dout_o(dout_o),
        .dout_oe(dout_oe), .byte_count_interrupt(irq)
    );
    bsp_ext_master bsp_ext_master_i (
        .sck(m_sck), .ss_n(m_ss_n), .mosi(m_mosi), .miso(miso)
    );
    initial begin
        forever #10 clock = ~clock;
    end
    // Counts every comparison and reports a mismatch at once.
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    // Register write: one strobe cycle, then one idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        sfr_req = '{a, v, 1'b1, 1'b0};
        @(negedge clock);
        sfr_req.wr = 1'b0;
    endtask
    // Register read; the answer is registered one cycle later.
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        sfr_req = '{a, 8'h00, 1'b0, 1'b1};
        @(negedge clock);
        sfr_req.rd = 1'b0;
        rdv = sfr_rdata;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [7:0] e);
        rd(a);
        chk(nm, e, rdv);
    endtask
    // Bounded wait for the byte-complete interrupt.
    task automatic wait_irq();
        for (int i = 0; i < 40 && irq !== 1'b1; i++) @(negedge clock);
        chk("irq", 8'h01, {7'h0, irq});
    endtask
    // Software clock: each pair of writes makes one full clock.
    task automatic sclk(input int n);
        repeat (n) begin
            wr(bsp_pkg::ADDR_SRCSEL, 8'h80);
            wr(bsp_pkg::ADDR_SRCSEL, 8'h00);
        end
    endtask
    task automatic t_reset();
        rdc("power_control_reg", bsp_pkg::ADDR_POWER_CONTROL_REG, 8'h01);
        rdc("ctrl", bsp_pkg::ADDR_CTRL, 8'h00);
        rdc("aie", bsp_pkg::ADDR_AIE, 8'h00);
        rdc("srcsel", bsp_pkg::ADDR_SRCSEL, 8'h00);
        rdc("data", bsp_pkg::ADDR_DATA, 8'h00);
        wr(8'h55, 8'hFF);
        rdc("unmapped", 8'h55, 8'h00);
    endtask
    // Powered down, the pins simply mirror the port latches.
    task automatic t_pd();
        gpio = 4'hA;
        repeat (2) @(negedge clock);
        chk("pins", 8'h0A, {4'h0, sck_o, sck_oe, dout_o, dout_oe});
        gpio = 4'h5;
        repeat (2) @(negedge clock);
        chk("pins", 8'h05, {4'h0, sck_o, sck_oe, dout_o, dout_oe});
    endtask
    // Each hardware source in turn, with one event on its input.
    task automatic t_src();
        logic prev;
        wr(bsp_pkg::ADDR_CTRL, 8'h08);
        for (int k = 1; k < 7; k++) begin
            wr(bsp_pkg::ADDR_SRCSEL, 8'(k));
            repeat (3) @(negedge clock);
            prev = sck_o;
            stb[(k - 1) / 2] = 1'b1;
            @(negedge clock);
            stb = 3'h0;
            if (k % 2 == 1) begin
                chk("pulse", 8'(k > 1), 8'(sck_o));
            end else begin
                @(negedge clock);
                chk("toggle", 8'(!prev), 8'(sck_o));
            end
        end
    endtask
    // Master byte by software clocks, count read back mid-byte.
    task automatic t_master();
        wr(bsp_pkg::ADDR_AIE, 8'h04);
        wr(bsp_pkg::ADDR_SRCSEL, 8'h00);
        repeat (8) @(negedge clock);
        wr(bsp_pkg::ADDR_DATA, 8'hA5);
        sclk(3);
        repeat (6) @(negedge clock);
        rd(bsp_pkg::ADDR_CTRL);
        chk("count", 8'h03, {5'h0, rdv[7:5]});
        sclk(5);
        wait_irq();
        rdc("loop rx", bsp_pkg::ADDR_DATA, 8'hA5);
        chk("irq clr", 8'h00, {7'h0, irq});
    endtask
    // Slave byte clocked by the external master in the given mode.
    task automatic t_slave(input logic [7:0] c, input logic [7:0] dt,
        input logic [7:0] mt, input logic [7:0] er, input logic [7:0] em);
        wr(bsp_pkg::ADDR_CTRL, c);
        wr(bsp_pkg::ADDR_DATA, dt);
        bsp_ext_master_i.xfer(mt, c[1], c[0], 8, 1'b0, mrx);
        chk("master rx", em, mrx);
        wait_irq();
        rdc("slave rx", bsp_pkg::ADDR_DATA, er);
    endtask
    // Clocks with select high must be ignored entirely.
    task automatic t_refuse();
        wr(bsp_pkg::ADDR_CTRL, 8'h10);
        wr(bsp_pkg::ADDR_DATA, 8'h00);
        bsp_ext_master_i.xfer(8'hFF, 1'b0, 1'b0, 8, 1'b1, mrx);
        chk("dout oe", 8'h00, {7'h0, dout_oe});
        rd(bsp_pkg::ADDR_CTRL);
        chk("idle count", 8'h00, {5'h0, rdv[7:5]});
        chk("no irq", 8'h00, {7'h0, irq});
    endtask
    // Unread byte then a new frame: the flag is withdrawn.
    task automatic t_overrun();
        bsp_ext_master_i.xfer(8'h5A, 1'b0, 1'b0, 8, 1'b0, mrx);
        wait_irq();
        bsp_ext_master_i.xfer(8'h00, 1'b0, 1'b0, 3, 1'b0, mrx);
        repeat (6) @(negedge clock);
        chk("withdrawn", 8'h00, {7'h0, irq});
        rd(bsp_pkg::ADDR_DATA);
        repeat (6) @(negedge clock);
        rd(bsp_pkg::ADDR_CTRL);
        chk("count clr", 8'h00, {5'h0, rdv[7:5]});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence; bus, strobe and latch inputs change on the falling edge only.
    initial begin
        repeat (16) @(negedge clock);
        sys_rst = 1'b0;
        t_reset();
        t_pd();
        wr(bsp_pkg::ADDR_POWER_CONTROL_REG, 8'h00);
        gpio = '0;
        t_src();
        t_master();
        // Select disabled first, while clock idle and phase agree.
        t_slave(8'h00, 8'h96, 8'h69, 8'h69, 8'h96);
        t_slave(8'h10, 8'h3C, 8'hC3, 8'hC3, 8'h3C);
        t_slave(8'h11, 8'h3C, 8'hC3, 8'hC3, 8'h3C);
        t_slave(8'h12, 8'h3C, 8'hC3, 8'hC3, 8'h3C);
        t_slave(8'h17, 8'h0F, 8'h12, 8'h48, 8'hF0);
        t_refuse();
        t_overrun();
        print_verdict();
    end
    // Whole run needs a few hundred cycles; this is far beyond.
    initial begin
        #400000;
        n_fail++;
        print_verdict();
    end
endmodule
